// *** hw/pdl_pkg.sv ***
`default_nettype none
package pdl_pkg;
   // ***************************************************************
   // Word format
   // ***************************************************************
   localparam int unsigned WORD_WIDTH = 10;
   localparam logic [9:0] CODE_FULL_SCALE = 10'h3ff;
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam logic [10:0] CURRENT_UNITS_FS = 11'h3ff;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLOCK_HZ = 25000000;
   localparam int unsigned CLOCK_NS = 40;
   localparam int unsigned WAKE_TIME_US = 3250;
   localparam int unsigned SLEEP_TIME_NS = 5000;
   localparam int unsigned WAKE_CYCLES =
      (WAKE_TIME_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
   localparam int unsigned SLEEP_CYCLES =
      (SLEEP_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int unsigned MAX_RATE_SPS = 125000000;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam logic [16:0] COUNT_ZERO = 17'h00000;
endpackage
`default_nettype wire

// *** hw/pdl_link_if.sv ***
`default_nettype none
interface pdl_link_if;
   logic [9:0] sample_word;
   logic       sample_valid;
   logic       sample_ready;
   logic       power_down;
   logic       power_down_oe;

   // Pull-down: an undriven power-down pin reads as zero
   logic       power_down_pin;
   assign power_down_pin = power_down_oe ? power_down : 1'b0;

   modport source (
      output sample_word,
      output sample_valid,
      input  sample_ready,
      output power_down,
      output power_down_oe
   );
   modport converter (
      input sample_word,
      input sample_valid,
      output sample_ready,
      input power_down_pin
   );
endinterface
`default_nettype wire

// *** hw/pdl_converter.sv ***
// Overview of operation
// - Ten-bit straight binary word, MSB highest pin.
// - All ones gives full scale on true output.
// - Word captured by edge-triggered master-slave latch.
// - Output updates only after rising edge.
// - Clock high and low phases meet width.
// - Source changes data at falling edge (pdl_source updates it at the rising edge).
// - Power-down high turns output current off.
// - Power-down input pulled low when unconnected.
// - Allow wake time before trusting output.
// - No power-down with overdriven reference amplifier.
`default_nettype none
module pdl_converter
   import pdl_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_b,
   pdl_link_if.converter     link,
   output var  logic [10:0]  true_current_output,
   output var  logic [10:0]  complement_current_output,
   output var  logic [9:0]   latched_code,
   output var  logic         standby,
   output var  logic         output_valid
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef enum logic [1:0] {
      PDL_RUN,
      PDL_ASLEEP,
      PDL_WAKING
   } pdl_mode_type;

   typedef struct packed {
      logic [2:0]   pd_sync;
      logic [1:0][9:0] buf_word;
      logic [1:0]   buf_count;
      logic         wr_ptr;
      logic         rd_ptr;
      logic [9:0]   slave;
      logic [10:0]  iout_true;
      logic [10:0]  iout_comp;
      pdl_mode_type mode;
      logic [16:0]  wake_count;
      logic         valid;
      logic         standby;
   } pdl_conv_type;

   pdl_conv_type s_q;
   pdl_conv_type s_d;

   logic buf_push;
   logic buf_pop;
   logic pd_level;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic pdl_is_asleep(input pdl_mode_type m);
      return (m == PDL_ASLEEP);
   endfunction

   function automatic logic pdl_is_awake(input pdl_mode_type m);
      return (m == PDL_RUN);
   endfunction

   function automatic logic pdl_buf_full(input logic [1:0] count);
      return (count == BUF_DEPTH);
   endfunction

   function automatic logic pdl_buf_empty(input logic [1:0] count);
      return (count == 2'h0);
   endfunction

   function automatic logic pdl_wake_done(input logic [16:0] count);
      return (count == 17'(WAKE_CYCLES - 1));
   endfunction

   function automatic logic [10:0] pdl_true_units(input logic [9:0] c);
      return {1'b0, c};
   endfunction

   // Complement leg carries what the true leg leaves of full scale
   function automatic logic [10:0] pdl_comp_units(input logic [9:0] c);
      return CURRENT_UNITS_FS - {1'b0, c};
   endfunction

   // Pointers step only when their side moves a word
   function automatic logic pdl_ptr_step(input logic ptr,
                                         input logic move);
      return ptr ^ move;
   endfunction

   // Push and pop in one cycle leave the fill level as it was
   function automatic logic [1:0] pdl_next_count(input logic [1:0] count,
                                                 input logic       push,
                                                 input logic       pop);
      return count + {1'b0, push} - {1'b0, pop};
   endfunction

   // A lone disagreeing stage is treated as noise: the old view stands
   function automatic logic pdl_pin_level(input logic [2:0] sync,
                                          input logic       held);
      logic level;
      if (sync[1] == sync[2]) begin
         level = sync[2];
      end else begin
         level = held;
      end
      return level;
   endfunction

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      // ***************************************************************
      // Pin filter and buffer
      // ***************************************************************
      // Three stages on the pin; a change counts once two agree
      s_d.pd_sync = {s_q.pd_sync[1:0], link.power_down_pin};
      pd_level = pdl_pin_level(s_q.pd_sync, pdl_is_asleep(s_q.mode));
      // The core is off in standby, so the buffer stops draining and
      // back-pressure holds the source instead of losing a word
      buf_push = link.sample_valid && !pdl_buf_full(s_q.buf_count);
      buf_pop = !pdl_buf_empty(s_q.buf_count) && !pdl_is_asleep(s_q.mode);
      // Master stage: the buffer holds words between edges
      if (buf_push) begin
         s_d.buf_word[s_q.wr_ptr] = link.sample_word;
      end
      s_d.wr_ptr = pdl_ptr_step(s_q.wr_ptr, buf_push);
      // Slave stage: takes a word only at the rising edge
      if (buf_pop) begin
         s_d.slave = s_q.buf_word[s_q.rd_ptr];
      end
      s_d.rd_ptr = pdl_ptr_step(s_q.rd_ptr, buf_pop);
      s_d.buf_count = pdl_next_count(s_q.buf_count, buf_push, buf_pop);

      // ***************************************************************
      // Power mode
      // ***************************************************************
      case (s_q.mode)
         PDL_RUN: begin
            if (pd_level) begin
               s_d.mode = PDL_ASLEEP;
            end
         end
         PDL_ASLEEP: begin
            if (!pd_level) begin
               s_d.mode = PDL_WAKING;
               s_d.wake_count = COUNT_ZERO;
            end
         end
         PDL_WAKING: begin
            if (pd_level) begin
               s_d.mode = PDL_ASLEEP;
            end else if (pdl_wake_done(s_q.wake_count)) begin
               s_d.mode = PDL_RUN;
            end else begin
               s_d.wake_count = s_q.wake_count + 17'h00001;
            end
         end
         default: begin
            // Unused code: park in standby so a wake restarts the count
            s_d.mode = PDL_ASLEEP;
         end
      endcase

      // ***************************************************************
      // Output currents
      // ***************************************************************
      s_d.valid = pdl_is_awake(s_d.mode);
      s_d.standby = pdl_is_asleep(s_d.mode);
      // Current split: true + complement equals full scale, except in standby where both are zero
      if (s_d.standby) begin
         s_d.iout_true = 11'h000;
         s_d.iout_comp = 11'h000;
      end else begin
         s_d.iout_true = pdl_true_units(s_d.slave);
         s_d.iout_comp = pdl_comp_units(s_d.slave);
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         // Zero code while running: the complement leg takes full scale
         s_q <= '0;
         s_q.iout_comp <= CURRENT_UNITS_FS;
         s_q.mode <= PDL_RUN;
         s_q.valid <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Ready is held until the buffer has room; never lose a word
   assign link.sample_ready = !pdl_buf_full(s_q.buf_count);
   assign true_current_output = s_q.iout_true;
   assign complement_current_output = s_q.iout_comp;
   assign latched_code = s_q.slave;
   assign standby = s_q.standby;
   assign output_valid = s_q.valid;
endmodule
`default_nettype wire

// *** hw/pdl_source.sv ***
`default_nettype none
module pdl_source
   import pdl_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   pdl_link_if.source       link,
   input  wire logic [9:0]  user_word,
   input  wire logic        user_valid,
   output var  logic        user_ready,
   input  wire logic        user_sleep,
   input  wire logic        ext_amp_present
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [9:0] word;
      logic       valid;
      logic       pd;
   } pdl_src_type;

   pdl_src_type s_q;
   pdl_src_type s_d;

   always_comb begin
      s_d = s_q;
      // Hold each word until the converter takes it
      if (!s_q.valid || link.sample_ready) begin
         s_d.valid = user_valid;
         if (user_valid) begin
            s_d.word = user_word;
         end
      end
      // Sleep is refused while an outside amplifier overdrives
      s_d.pd = user_sleep && !ext_amp_present;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign user_ready = !s_q.valid || link.sample_ready;
   assign link.sample_word = s_q.word;
   assign link.sample_valid = s_q.valid;
   assign link.power_down = s_q.pd;
   // Pin is released while awake; the pull-down then holds it low
   assign link.power_down_oe = s_q.pd;
endmodule
`default_nettype wire

// *** tb/pdl_link_asserts.sv ***
`default_nettype none
module pdl_link_asserts (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic [9:0]  sample_word,
   input wire logic        sample_valid,
   input wire logic        sample_ready,
   input wire logic        power_down_oe,
   input wire logic        power_down_pin,
   input wire logic [10:0] true_current_output,
   input wire logic [10:0] complement_current_output,
   input wire logic [9:0]  latched_code,
   input wire logic        standby,
   input wire logic        output_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // Link and output checks
   // *****
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   split_sum_a: assert property (output_valid |->
      true_current_output + complement_current_output == 11'h3ff)
      else $error("currents do not split full scale");
   code_track_a: assert property (output_valid |->
      true_current_output == {1'b0, latched_code})
      else $error("true current differs from code");
   standby_zero_a: assert property (standby |->
      true_current_output == 11'h000 && complement_current_output == 11'h000)
      else $error("current flows in standby");
   sleep_entry_a: assert property ($rose(power_down_pin) |->
      ##[1:5] standby) else $error("standby not entered");
   pin_pull_a: assert property (!power_down_oe |-> !power_down_pin)
      else $error("undriven power-down pin not low");
   word_hold_a: assert property (sample_valid && !sample_ready |=>
      sample_valid && $stable(sample_word))
      else $error("word dropped while refused");
   idle_hold_a: assert property (!sample_valid [*3] |=>
      $stable(latched_code)) else $error("latch moved with no word");
   sleep_freeze_a: assert property (standby |=> $stable(latched_code))
      else $error("latch moved in standby");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench
   import pdl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [9:0]  w;
      logic [10:0] t;
      logic [10:0] c;
   } pdl_row_type;
   // *****
   // Rows: word, true and complement current
   // *****
   localparam pdl_row_type ROWS [6] = '{
      '{10'h000, 11'h000, 11'h3ff}, '{10'h3ff, 11'h3ff, 11'h000},
      '{10'h200, 11'h200, 11'h1ff}, '{10'h001, 11'h001, 11'h3fe},
      '{10'h155, 11'h155, 11'h2aa}, '{10'h2aa, 11'h2aa, 11'h155}};
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic user_valid = 1'b0;
   logic user_sleep = 1'b0;
   logic amp = 1'b0;
   logic ready, stby, ov;
   logic [9:0] user_word = 10'h000, code;
   logic [10:0] t_out, c_out;
   int mismatches = 0, samples_checked = 0;
   pdl_link_if link();
   pdl_source u_pdl_source(.clock, .rst_b, .link, .user_word, .user_valid,
      .user_ready(ready), .user_sleep, .ext_amp_present(amp));
   pdl_converter u_pdl_converter(.clock, .rst_b, .link,
      .true_current_output(t_out), .complement_current_output(c_out),
      .latched_code(code), .standby(stby), .output_valid(ov));
   pdl_link_asserts u_pdl_link_asserts(.clock, .rst_b,
      .sample_word(link.sample_word), .sample_valid(link.sample_valid),
      .sample_ready(link.sample_ready), .power_down_oe(link.power_down_oe),
      .power_down_pin(link.power_down_pin), .true_current_output(t_out),
      .complement_current_output(c_out), .latched_code(code),
      .standby(stby), .output_valid(ov));
   initial forever #20 clock = ~clock;
   task automatic chk(input string n, input logic [10:0] e, s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // Called at a falling edge; leaves valid high for back-to-back use
   task automatic push(input logic [9:0] w);
      user_word = w;
      user_valid = 1;
      #1;
      while (ready !== 1'b1) @(negedge clock);
      @(negedge clock);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Wake wait dominates the run, so the limit sits just above it
   initial begin
      repeat (WAKE_CYCLES + 4000) @(posedge clock);
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (6) @(negedge clock);
      rst_b = 1;
      chk("comp", 11'h3ff, c_out);
      chk("valid", 11'h001, {10'h000, ov});
      $display("reset test done");
      foreach (ROWS[i]) begin
         push(ROWS[i].w);
         user_valid = 0;
         user_word = ~ROWS[i].w;
         repeat (3) @(negedge clock);
         chk("true", ROWS[i].t, t_out);
         chk("comp", ROWS[i].c, c_out);
      end
      $display("row test done");
      for (int k = 1; k < 9; k++) push(10'(k * 100));
      user_valid = 0;
      repeat (4) @(negedge clock);
      chk("code", 11'h320, {1'b0, code});
      $display("burst test done");
      rst_b = 0;
      #1;
      chk("code", 11'h000, {1'b0, code});
      chk("comp", 11'h3ff, c_out);
      repeat (2) @(negedge clock);
      rst_b = 1;
      chk("valid", 11'h001, {10'h000, ov});
      $display("mid reset test done");
      user_sleep = 1;
      amp = 1;
      repeat (8) @(negedge clock);
      chk("standby", 11'h000, {10'h000, stby});
      amp = 0;
      repeat (8) @(negedge clock);
      chk("standby", 11'h001, {10'h000, stby});
      chk("true", 11'h000, t_out);
      push(10'h0aa);
      push(10'h0bb);
      push(10'h2cc);
      user_valid = 0;
      chk("ready", 11'h000, {10'h000, ready});
      chk("code", 11'h000, {1'b0, code});
      user_sleep = 0;
      repeat (8) @(negedge clock);
      chk("valid", 11'h000, {10'h000, ov});
      repeat (WAKE_CYCLES) @(negedge clock);
      chk("valid", 11'h001, {10'h000, ov});
      chk("true", 11'h2cc, t_out);
      chk("comp", 11'h133, c_out);
      $display("sleep test done");
      end_of_test();
   end
endmodule
`default_nettype wire
